//--- rtl/aic_regs_top.sv
`timescale 1ns/10ps
module aic_regs_top
  import aic_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             firstIrqPinOut,
  output logic             firstIrqPinOe,
  output logic             secondIrqPinOut,
  output logic             secondIrqPinOe,
  input  wire logic        sampleReadyFlag,
  input  wire logic        progOneIrq,
  input  wire logic        progTwoIrq,
  input  wire logic        progOneIrqClr,
  input  wire logic        progTwoIrqClr,
  input  wire logic        progOneEnSet,
  input  wire logic        progOneEnClr,
  input  wire logic        axisValid,
  input  wire logic [11:0] xRaw,
  input  wire logic [11:0] yRaw,
  input  wire logic [11:0] zRaw,
  output logic             progOneEnable,
  output logic             progTwoEnable,
  output logic             progOneLaunch,
  output logic             progTwoLaunch,
  output logic [2:0]       progOneHyst,
  output logic [2:0]       progTwoHyst,
  output logic             vectorFilterEnable,
  output logic             selfTestEnable,
  output logic             overrunReset,
  output logic             corrValid,
  output logic [11:0]      xCorr,
  output logic [11:0]      yCorr,
  output logic [11:0]      zCorr,
  output logic [7:0]       xShift,
  output logic [7:0]       yShift
);
  function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] o);
    return stb && (a == o);
  endfunction

  // saturating rather than wrapping so a large offset cannot flip the sign
  function automatic logic [11:0] corrAxis(input logic [11:0] raw, input logic [7:0] off);
    logic signed [13:0] d;
    d = $signed({{2{raw[11]}}, raw}) - $signed({{5{off[7]}}, off, 1'b0});
    if (d[13:11] == 3'b000 || d[13:11] == 3'b111) return d[11:0];
    return d[13] ? SAT_NEG : SAT_POS;
  endfunction

  function automatic logic [7:0] mag8(input logic [11:0] v);
    logic [7:0] t;
    t = v[11:MAG_LSB];
    return t[7] ? 8'(~t + 8'h01) : t;
  endfunction

  logic [7:0]  regAddr;
  logic [7:0]  wrData;
  logic        wrStb;
  logic [7:0]  rdData;
  logic [7:0]  main_q;
  logic [7:0]  p1Ctl_q;
  logic [7:0]  p2Ctl_q;
  logic [7:1]  misc_q;
  logic        srst_q;
  logic [7:0]  thr_q;
  logic [7:0]  offX_q;
  logic [7:0]  offY_q;
  logic [7:0]  offZ_q;
  logic [7:0]  csX_q;
  logic [7:0]  csY_q;
  logic        p1Launch_q;
  logic        p2Launch_q;
  logic        p1Pend_q;
  logic        p2Pend_q;
  logic        ovr_q;
  logic        cValid_q;
  logic [11:0] xC_q;
  logic [11:0] yC_q;
  logic [11:0] zC_q;
  logic        p1Wr;
  logic        p2Wr;
  logic        p1EnD;
  logic        p2EnD;
  logic [11:0] corrX;
  logic [11:0] corrY;
  logic [11:0] corrZ;
  logic        overAny;
  logic        act1;
  logic        act2;
  logic        pinOneAct;
  logic        pinTwoAct;
  logic        drRoute;

  aic_i2c_slave #(.DEV_ADDR(DEV_ADDR)) uI2c (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .regAddr (regAddr),
    .wrData  (wrData),
    .wrStb   (wrStb),
    .rdData  (rdData)
  );

  assign p1Wr = hit(wrStb, regAddr, ADDR_P1);
  assign p2Wr = hit(wrStb, regAddr, ADDR_P2);

  // host write lands after program code, so it wins over program code in the same cycle
  always_comb begin
    p1EnD = p1Ctl_q[BIT_PEN];
    if (progOneEnClr) p1EnD = 1'b0;
    if (progOneEnSet) p1EnD = 1'b1;
    if (p1Wr) p1EnD = wrData[BIT_PEN];
    if (srst_q) p1EnD = 1'b0;
    p2EnD = p2Ctl_q[BIT_PEN];
    if (p2Wr) p2EnD = wrData[BIT_PEN];
    if (srst_q) p2EnD = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      main_q  <= RST_MAIN;
      p1Ctl_q <= RST_ZERO;
      p2Ctl_q <= RST_ZERO;
      misc_q  <= RST_ZERO[7:1];
      srst_q  <= 1'b0;
      thr_q   <= RST_ZERO;
      offX_q  <= RST_ZERO;
      offY_q  <= RST_ZERO;
      offZ_q  <= RST_ZERO;
      csX_q   <= RST_ZERO;
      csY_q   <= RST_ZERO;
    end else if (clkEn) begin
      if (srst_q) begin
        main_q  <= RST_MAIN;
        p1Ctl_q <= RST_ZERO;
        p2Ctl_q <= RST_ZERO;
        misc_q  <= RST_ZERO[7:1];
        srst_q  <= 1'b0;
        thr_q   <= RST_ZERO;
        offX_q  <= RST_ZERO;
        offY_q  <= RST_ZERO;
        offZ_q  <= RST_ZERO;
        csX_q   <= RST_ZERO;
        csY_q   <= RST_ZERO;
      end else begin
        // halting only drops the enable; hysteresis and route stay as they were
        p1Ctl_q[BIT_PEN] <= p1EnD;
        p2Ctl_q[BIT_PEN] <= p2EnD;
        if (p1Wr) p1Ctl_q[7:1] <= wrData[7:1] & PROG_MASK[7:1];
        if (p2Wr) p2Ctl_q[7:1] <= wrData[7:1] & PROG_MASK[7:1];
        if (hit(wrStb, regAddr, ADDR_MAIN)) main_q <= wrData;
        if (hit(wrStb, regAddr, ADDR_MISC)) begin
          misc_q <= wrData[7:1];
          srst_q <= wrData[BIT_SRST];
        end
        if (hit(wrStb, regAddr, ADDR_OVR)) thr_q <= wrData;
        if (hit(wrStb, regAddr, ADDR_OFFX)) offX_q <= wrData;
        if (hit(wrStb, regAddr, ADDR_OFFY)) offY_q <= wrData;
        if (hit(wrStb, regAddr, ADDR_OFFZ)) offZ_q <= wrData;
        if (hit(wrStb, regAddr, ADDR_CSX)) csX_q <= wrData;
        if (hit(wrStb, regAddr, ADDR_CSY)) csY_q <= wrData;
      end
    end
  end

  always_comb begin
    case (regAddr)
      ADDR_MAIN: rdData = main_q;
      ADDR_P1:   rdData = p1Ctl_q & PROG_MASK;
      ADDR_P2:   rdData = p2Ctl_q & PROG_MASK;
      ADDR_MISC: rdData = {misc_q, srst_q};
      ADDR_OVR:  rdData = thr_q;
      ADDR_OFFX: rdData = offX_q;
      ADDR_OFFY: rdData = offY_q;
      ADDR_OFFZ: rdData = offZ_q;
      ADDR_CSX:  rdData = csX_q;
      ADDR_CSY:  rdData = csY_q;
      default:   rdData = RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1Launch_q <= 1'b0;
      p2Launch_q <= 1'b0;
    end else if (clkEn) begin
      p1Launch_q <= p1EnD & ~p1Ctl_q[BIT_PEN];
      p2Launch_q <= p2EnD & ~p2Ctl_q[BIT_PEN];
    end
  end

  // pending flags: a new event in the clearing cycle is kept
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1Pend_q <= 1'b0;
      p2Pend_q <= 1'b0;
    end else if (clkEn) begin
      p1Pend_q <= progOneIrq | (p1Pend_q & ~progOneIrqClr & ~srst_q);
      p2Pend_q <= progTwoIrq | (p2Pend_q & ~progTwoIrqClr & ~srst_q);
    end
  end

  assign drRoute   = misc_q[BIT_DRR];
  assign act1      = misc_q[BIT_PULSE] ? progOneIrq : (p1Pend_q | progOneIrq);
  assign act2      = misc_q[BIT_PULSE] ? progTwoIrq : (p2Pend_q | progTwoIrq);
  assign pinTwoAct = main_q[BIT_IEN] &
                     ((p1Ctl_q[BIT_ROUTE] & act1) | (p2Ctl_q[BIT_ROUTE] & act2));
  assign pinOneAct = drRoute ? sampleReadyFlag :
                     main_q[BIT_IEN] &
                     ((~p1Ctl_q[BIT_ROUTE] & act1) | (~p2Ctl_q[BIT_ROUTE] & act2));

  aic_irq_pad uPadOne (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .clkEn      (clkEn),
    .pinEnable  (misc_q[BIT_EN1]),
    .activeHigh (misc_q[BIT_POL]),
    .active     (pinOneAct),
    .pinOut     (firstIrqPinOut),
    .pinOe      (firstIrqPinOe)
  );

  aic_irq_pad uPadTwo (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .clkEn      (clkEn),
    .pinEnable  (misc_q[BIT_EN2]),
    .activeHigh (misc_q[BIT_POL]),
    .active     (pinTwoAct),
    .pinOut     (secondIrqPinOut),
    .pinOe      (secondIrqPinOe)
  );

  assign corrX   = corrAxis(xRaw, offX_q);
  assign corrY   = corrAxis(yRaw, offY_q);
  assign corrZ   = corrAxis(zRaw, offZ_q);
  // magnitude of the top byte; axis masks play no part here
  assign overAny = (mag8(corrX) > thr_q) | (mag8(corrY) > thr_q) | (mag8(corrZ) > thr_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovr_q    <= 1'b0;
      cValid_q <= 1'b0;
      xC_q     <= 12'h000;
      yC_q     <= 12'h000;
      zC_q     <= 12'h000;
    end else if (clkEn) begin
      ovr_q    <= axisValid & overAny;
      cValid_q <= axisValid;
      if (axisValid) begin
        xC_q <= corrX;
        yC_q <= corrY;
        zC_q <= corrZ;
      end
    end
  end

  assign progOneEnable      = p1Ctl_q[BIT_PEN];
  assign progTwoEnable      = p2Ctl_q[BIT_PEN];
  assign progOneLaunch      = p1Launch_q;
  assign progTwoLaunch      = p2Launch_q;
  assign progOneHyst        = p1Ctl_q[HYST_MSB:HYST_LSB];
  assign progTwoHyst        = p2Ctl_q[HYST_MSB:HYST_LSB];
  assign vectorFilterEnable = misc_q[BIT_VF];
  assign selfTestEnable     = misc_q[BIT_ST];
  assign overrunReset       = ovr_q;
  assign corrValid          = cValid_q;
  assign xCorr              = xC_q;
  assign yCorr              = yC_q;
  assign zCorr              = zC_q;
  assign xShift             = csX_q;
  assign yShift             = csY_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  irqGate_a: assert property (
    clkEn && !main_q[BIT_IEN] && !drRoute && misc_q[BIT_EN1]
    |=> firstIrqPinOe && firstIrqPinOut == !$past(misc_q[BIT_POL]))
    else $error("first pin active while master enable is off");
  hystWrite_a: assert property (
    clkEn && !srst_q && p1Wr |=> progOneHyst == $past(wrData[HYST_MSB:HYST_LSB]))
    else $error("hysteresis field not taken from write");
  routeTwo_a: assert property (
    clkEn && main_q[BIT_IEN] && p2Ctl_q[BIT_ROUTE] && act2 && misc_q[BIT_EN2]
    |=> secondIrqPinOut == $past(misc_q[BIT_POL]))
    else $error("program two event missing on second pin");
  launchEdge_a: assert property (
    clkEn && !p1Ctl_q[BIT_PEN] && p1EnD |=> progOneLaunch && progOneEnable)
    else $error("enable rise did not launch program one");
  codeSet_a: assert property (
    clkEn && !srst_q && progOneEnSet && !p1Wr |=> progOneEnable)
    else $error("program code could not set its enable");
  haltKeep_a: assert property (
    clkEn && !srst_q && progOneEnClr && !progOneEnSet && !p1Wr
    |=> !progOneEnable && $stable(progOneHyst))
    else $error("halt lost enable clear or disturbed state");
  runLaunch_a: assert property (
    progOneLaunch |-> progOneEnable)
    else $error("launch while program disabled");
  readyOverride_a: assert property (
    clkEn && drRoute && misc_q[BIT_EN1]
    |=> firstIrqPinOut == !($past(sampleReadyFlag) ^ $past(misc_q[BIT_POL])))
    else $error("first pin does not follow data ready");
  pinFloat_a: assert property (
    clkEn && !misc_q[BIT_EN2] && !misc_q[BIT_EN1] |=> !secondIrqPinOe && !firstIrqPinOe)
    else $error("disabled pin is driven");
  softReset_a: assert property (
    clkEn && srst_q |=> main_q == RST_MAIN && p1Ctl_q == RST_ZERO && thr_q == RST_ZERO && !srst_q)
    else $error("soft reset did not reload defaults");
  overrunHit_a: assert property (
    clkEn && axisValid && (mag8(corrX) > thr_q) |=> overrunReset)
    else $error("overrun not flagged");
  offsetCorr_a: assert property (
    clkEn && axisValid |=> ($past(offX_q[7]) ? $signed(xCorr) >= $signed($past(xRaw))
                                             : $signed(xCorr) <= $signed($past(xRaw))))
    else $error("offset correction moved the axis the wrong way");
  fixedZero_a: assert property (
    regAddr == ADDR_P1 |-> (rdData & ~PROG_MASK) == RST_ZERO)
    else $error("fixed-zero bit reads one");
endmodule

//--- rtl/aic_pkg.sv
package aic_pkg;
  localparam logic [7:0] ADDR_MAIN = 8'h1B;
  localparam logic [7:0] ADDR_P1   = 8'h1C;
  localparam logic [7:0] ADDR_P2   = 8'h1D;
  localparam logic [7:0] ADDR_MISC = 8'h1E;
  localparam logic [7:0] ADDR_OVR  = 8'h1F;
  localparam logic [7:0] ADDR_OFFX = 8'h20;
  localparam logic [7:0] ADDR_OFFY = 8'h21;
  localparam logic [7:0] ADDR_OFFZ = 8'h22;
  localparam logic [7:0] ADDR_CSX  = 8'h24;
  localparam logic [7:0] ADDR_CSY  = 8'h25;

  localparam logic [7:0] RST_MAIN  = 8'h14;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] PROG_MASK = 8'hE9;

  localparam int BIT_IEN   = 0;
  localparam int BIT_PEN   = 0;
  localparam int BIT_ROUTE = 3;
  localparam int HYST_LSB  = 5;
  localparam int HYST_MSB  = 7;
  localparam int BIT_DRR   = 7;
  localparam int BIT_POL   = 6;
  localparam int BIT_PULSE = 5;
  localparam int BIT_EN2   = 4;
  localparam int BIT_EN1   = 3;
  localparam int BIT_VF    = 2;
  localparam int BIT_ST    = 1;
  localparam int BIT_SRST  = 0;

  localparam logic [11:0] SAT_POS = 12'h7FF;
  localparam logic [11:0] SAT_NEG = 12'h800;
  localparam int          MAG_LSB = 4;
  localparam logic [3:0]  BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'h0,
    I2C_DEV  = 4'h1,
    I2C_ACKD = 4'h2,
    I2C_REG  = 4'h3,
    I2C_ACKR = 4'h4,
    I2C_WR   = 4'h5,
    I2C_ACKW = 4'h6,
    I2C_RD   = 4'h7,
    I2C_RACK = 4'h8
  } aic_i2c_e;
endpackage

//--- rtl/aic_irq_pad.sv
`timescale 1ns/10ps
module aic_irq_pad
  import aic_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic pinEnable,
  input  wire logic activeHigh,
  input  wire logic active,
  output logic      pinOut,
  output logic      pinOe
);
  logic pinOut_q;
  logic pinOe_q;

  // disabled pad floats; enabled pad is push-pull at the chosen polarity
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinOut_q <= 1'b0;
      pinOe_q  <= 1'b0;
    end else if (clkEn) begin
      pinOe_q  <= pinEnable;
      pinOut_q <= pinEnable & ~(active ^ activeHigh);
    end
  end

  assign pinOut = pinOut_q;
  assign pinOe  = pinOe_q;
endmodule

//--- rtl/aic_i2c_slave.sv
`timescale 1ns/10ps
module aic_i2c_slave
  import aic_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [7:0]      regAddr,
  output logic [7:0]      wrData,
  output logic            wrStb,
  input  wire logic [7:0] rdData
);
  if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : gChk
    $error("device address lies in a reserved range");
  end

  logic [2:0] sclS_q;
  logic [2:0] sdaS_q;
  logic       scl_q;
  logic       sda_q;
  logic       sclPrev_q;
  logic       sdaPrev_q;
  aic_i2c_e   st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic       rw_q;
  logic       nack_q;
  logic       oe_q;
  logic [7:0] addr_q;
  logic [7:0] wd_q;
  logic       stb_q;
  logic       sclRise;
  logic       sclFall;
  logic       startC;
  logic       stopC;

  // a level counts only once the second and third stages agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclS_q    <= 3'h7;
      sdaS_q    <= 3'h7;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclS_q    <= {sclS_q[1:0], sclIn};
      sdaS_q    <= {sdaS_q[1:0], sdaIn};
      if (sclS_q[1] == sclS_q[2]) scl_q <= sclS_q[2];
      if (sdaS_q[1] == sdaS_q[2]) sda_q <= sdaS_q[2];
      sclPrev_q <= scl_q;
      sdaPrev_q <= sda_q;
    end
  end

  assign sclRise = scl_q & ~sclPrev_q;
  assign sclFall = ~scl_q & sclPrev_q;
  assign startC  = scl_q & sclPrev_q & sdaPrev_q & ~sda_q;
  assign stopC   = scl_q & sclPrev_q & ~sdaPrev_q & sda_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q   <= I2C_IDLE;
      cnt_q  <= 4'h0;
      sh_q   <= 8'h00;
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
      oe_q   <= 1'b0;
      addr_q <= 8'h00;
      wd_q   <= 8'h00;
      stb_q  <= 1'b0;
    end else if (clkEn) begin
      stb_q <= 1'b0;
      if (startC) begin
        st_q  <= I2C_DEV;
        cnt_q <= 4'h0;
        oe_q  <= 1'b0;
      end else if (stopC) begin
        st_q <= I2C_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (st_q)
          I2C_DEV, I2C_REG, I2C_WR: begin
            if (sclRise) begin
              sh_q  <= {sh_q[6:0], sda_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (sclFall && cnt_q == BYTE_BITS) begin
              cnt_q <= 4'h0;
              oe_q  <= 1'b1;
              if (st_q == I2C_DEV) begin
                rw_q <= sh_q[0];
                if (sh_q[7:1] == DEV_ADDR) st_q <= I2C_ACKD;
                else begin
                  st_q <= I2C_IDLE;
                  oe_q <= 1'b0;
                end
              end else if (st_q == I2C_REG) begin
                addr_q <= sh_q;
                st_q   <= I2C_ACKR;
              end else begin
                wd_q  <= sh_q;
                stb_q <= 1'b1;
                st_q  <= I2C_ACKW;
              end
            end
          end
          I2C_ACKD: begin
            if (sclFall) begin
              if (rw_q) begin
                sh_q <= rdData;
                oe_q <= ~rdData[7];
                st_q <= I2C_RD;
              end else begin
                oe_q <= 1'b0;
                st_q <= I2C_REG;
              end
            end
          end
          I2C_ACKR: begin
            if (sclFall) begin
              oe_q <= 1'b0;
              st_q <= I2C_WR;
            end
          end
          I2C_ACKW: begin
            if (sclFall) begin
              oe_q   <= 1'b0;
              addr_q <= addr_q + 8'h01;
              st_q   <= I2C_WR;
            end
          end
          I2C_RD: begin
            if (sclRise) cnt_q <= cnt_q + 4'h1;
            else if (sclFall) begin
              if (cnt_q == BYTE_BITS) begin
                cnt_q <= 4'h0;
                oe_q  <= 1'b0;
                st_q  <= I2C_RACK;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                oe_q <= ~sh_q[6];
              end
            end
          end
          I2C_RACK: begin
            // advance on the ack clock so the next byte is ready by its fall
            if (sclRise) begin
              nack_q <= sda_q;
              addr_q <= addr_q + 8'h01;
            end else if (sclFall) begin
              if (nack_q) st_q <= I2C_IDLE;
              else begin
                sh_q <= rdData;
                oe_q <= ~rdData[7];
                st_q <= I2C_RD;
              end
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sdaOut  = 1'b0;
  assign sdaOe   = oe_q;
  assign regAddr = addr_q;
  assign wrData  = wd_q;
  assign wrStb   = stb_q;
endmodule

//--- verif/aic_host_model.sv
`timescale 1ns/10ps
// scl is never stretched; sda has a pull-up, so a released line reads 1
module aic_host_model (
  input  wire logic ref_clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic bitx(input logic b, output logic s);
    sdaLow = ~b;
    hw(5);
    scl = 1'b1;
    hw(5);
    s = sdaLine;
    hw(5);
    scl = 1'b0;
    hw(5);
  endtask
  // st high: start or repeated start, low: stop
  task automatic cond(input logic st);
    sdaLow = ~st;
    hw(5);
    scl = 1'b1;
    hw(10);
    sdaLow = st;
    hw(10);
    scl = ~st;
    hw(5);
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, a);
    ack = ~a;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k1, k2, k3;
    cond(1'b1);
    xb({dev, 1'b0}, r, k1);
    xb(a, r, k2);
    xb(d, r, k3);
    cond(1'b0);
    ok = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k1, k2, k3, k4;
    cond(1'b1);
    xb({dev, 1'b0}, r, k1);
    xb(a, r, k2);
    cond(1'b1);
    xb({dev, 1'b1}, r, k3);
    xb(8'hFF, d, k4);
    cond(1'b0);
    ok = k1 & k2 & k3;
  endtask
endmodule

//--- verif/accel_interrupt_control_regs_bench.sv
`timescale 1ns/10ps
module accel_interrupt_control_regs_bench;
  import aic_pkg::*;
  localparam logic [6:0] DEV = 7'h2A;  // arbitrary value
  logic        ref_clk = 1'b0;
  logic        rst, scl, sdaLow, sdaOe, ok, rdy, i1, i2, c1, c2, es, ec, av, ce;
  logic        p1o, p1e, p2o, p2e, en1, en2, la1, la2, vf, st, ovr, cv;
  logic [2:0]  h1, h2;
  logic [7:0]  xs, ys, d;
  logic [7:0]  v [0:9];
  logic [11:0] xr, yr, zr, xc, yc, zc;
  int          err_count = 0;
  int          n_tests = 0;
  int          l1 = 0;
  int          l2 = 0;
  wire         sdaLine = ~(sdaLow | sdaOe);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    l1 <= l1 + (la1 === 1'b1);
    l2 <= l2 + (la2 === 1'b1);
  end
  aic_host_model u_host (.ref_clk(ref_clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
  aic_regs_top #(.DEV_ADDR(DEV)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .clkEn(ce), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
    .firstIrqPinOut(p1o), .firstIrqPinOe(p1e), .secondIrqPinOut(p2o), .secondIrqPinOe(p2e),
    .sampleReadyFlag(rdy), .progOneIrq(i1), .progTwoIrq(i2), .progOneIrqClr(c1), .progTwoIrqClr(c2),
    .progOneEnSet(es), .progOneEnClr(ec), .axisValid(av), .xRaw(xr), .yRaw(yr), .zRaw(zr),
    .progOneEnable(en1), .progTwoEnable(en2), .progOneLaunch(la1), .progTwoLaunch(la2),
    .progOneHyst(h1), .progTwoHyst(h2), .vectorFilterEnable(vf), .selfTestEnable(st),
    .overrunReset(ovr), .corrValid(cv), .xCorr(xc), .yCorr(yc), .zCorr(zc), .xShift(xs), .yShift(ys));
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] x);
    u_host.wr(DEV, a, x, ok);
    chk("ack", 1, ok);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(DEV, a, d, ok);
    chk("ack", 1, ok);
    chk($sformatf("reg %h", a), e, d);
  endtask
  // pins seen as {first oe, first out, second oe, second out}
  task automatic ev(input logic s, input logic [3:0] e1, input logic [3:0] e2, input logic [3:0] e3);
    {i2, i1} = s ? 2'b10 : 2'b01;
    @(negedge ref_clk);
    {i2, i1} = 2'b00;
    chk("pins", e1, {p1e, p1o, p2e, p2o});
    @(negedge ref_clk);
    chk("pins", e2, {p1e, p1o, p2e, p2o});
    {c2, c1} = 2'b11;
    @(negedge ref_clk);
    {c2, c1} = 2'b00;
    @(negedge ref_clk);
    chk("pins", e3, {p1e, p1o, p2e, p2o});
  endtask
  function automatic logic [11:0] cor(input logic [11:0] a, input logic [7:0] o);
    int t;
    t = $signed(a) - 2 * $signed(o);
    if (t > 2047) return SAT_POS;
    if (t < -2048) return SAT_NEG;
    return t[11:0];
  endfunction
  function automatic logic big(input logic [11:0] c, input logic [7:0] th);
    int m;
    m = $signed(c[11:4]);
    return (m < 0 ? -m : m) > th;
  endfunction
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {rdy, i1, i2, c1, c2, es, ec, av} = '0;
    {xr, yr, zr} = '0;
    void'($urandom(32'h23a6));
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 10; i++) r(8'h1B + i + (i > 7), i ? RST_ZERO : RST_MAIN);
    r(8'h23, 8'h00);
    $display("reset values done");
    for (int i = 1; i < 10; i++) begin
      v[i] = 8'($urandom);
      if (i == 3) v[i][0] = 1'b0;
      w(8'h1B + i + (i > 7), v[i]);
      r(8'h1B + i + (i > 7), (i < 3) ? v[i] & PROG_MASK : v[i]);
    end
    chk("hyst1", v[1][7:5], h1);
    chk("hyst2", v[2][7:5], h2);
    chk("filter", v[3][2], vf);
    chk("selftest", v[3][1], st);
    chk("xshift", v[8], xs);
    chk("yshift", v[9], ys);
    $display("register access done");
    v[4] = 8'h40;
    v[5] = 8'h80;
    w(ADDR_OVR, v[4]);
    w(ADDR_OFFX, v[5]);
    for (int i = 0; i < 12; i++) begin
      {xr, yr, zr} = {12'($urandom), 12'($urandom), 12'($urandom)};
      if (i == 0) xr = 12'h7FF;
      av = 1'b1;
      @(negedge ref_clk);
      av = 1'b0;
      chk("valid", 1, cv);
      chk("xcorr", cor(xr, v[5]), xc);
      chk("ycorr", cor(yr, v[6]), yc);
      chk("zcorr", cor(zr, v[7]), zc);
      chk("overrun", big(cor(xr, v[5]), v[4]) | big(cor(yr, v[6]), v[4]) | big(cor(zr, v[7]), v[4]), ovr);
    end
    // clock enable low must freeze the corrected outputs
    ce = 1'b0;
    av = 1'b1;
    xr = ~xr;
    @(negedge ref_clk);
    {ce, av} = 2'b10;
    chk("frozen", cor(~xr, v[5]), xc);
    chk("valid", 1, cv);
    $display("axis correction done");
    w(ADDR_P1, 8'h00);
    l1 = 0;
    w(ADDR_P1, 8'h01);
    w(ADDR_P1, 8'h01);
    chk("launch1", 1, l1);
    chk("en1", 1, en1);
    w(ADDR_P1, 8'h00);
    chk("en1", 0, en1);
    es = 1'b1;
    @(negedge ref_clk);
    es = 1'b0;
    chk("en1", 1, en1);
    ec = 1'b1;
    @(negedge ref_clk);
    ec = 1'b0;
    chk("en1", 0, en1);
    chk("launch1", 2, l1);
    w(ADDR_P2, 8'h00);
    l2 = 0;
    w(ADDR_P2, 8'h09);
    chk("launch2", 1, l2);
    chk("en2", 1, en2);
    w(ADDR_P2, 8'h08);
    $display("program enables done");
    w(ADDR_MAIN, 8'h15);
    w(ADDR_MISC, 8'h58);
    ev(0, 4'hE, 4'hE, 4'hA);
    ev(1, 4'hB, 4'hB, 4'hA);
    w(ADDR_MISC, 8'h78);
    ev(1, 4'hB, 4'hA, 4'hA);
    w(ADDR_MISC, 8'h38);
    ev(1, 4'hE, 4'hF, 4'hF);
    w(ADDR_MAIN, 8'h14);
    ev(0, 4'hF, 4'hF, 4'hF);
    w(ADDR_MISC, 8'hD8);
    chk("pins", 4'hA, {p1e, p1o, p2e, p2o});
    rdy = 1'b1;
    @(negedge ref_clk);
    chk("pins", 4'hE, {p1e, p1o, p2e, p2o});
    rdy = 1'b0;
    w(ADDR_MISC, 8'h40);
    chk("oe", 2'b00, {p1e, p2e});
    $display("interrupt pins done");
    w(ADDR_MAIN, 8'hA5);
    w(ADDR_MISC, 8'h01);
    r(ADDR_MISC, RST_ZERO);
    r(ADDR_P2, RST_ZERO);
    r(ADDR_MAIN, RST_MAIN);
    u_host.wr(DEV ^ 7'h01, ADDR_OVR, 8'h55, ok);
    chk("nack", 0, ok);
    r(ADDR_OVR, RST_ZERO);
    $display("soft reset done");
    complete_run;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    complete_run;
  end
endmodule
